/* logic/baud_echo_pkg.sv */
`default_nettype none
package baud_echo_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] CMD_OFF    = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] RXDATA_OFF = 8'h0c;
   // control fields
   localparam int DIV_LSB      = 0;
   localparam int RXCLK_BIT    = 4;
   // command fields
   localparam int ENABLE_BIT   = 0;
   localparam int RXIRQ_BIT    = 1;
   localparam int TXCTL_LSB    = 2;
   localparam int ECHO_BIT     = 4;
   localparam logic [1:0] TXCTL_NOIRQ = 2'h2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CMD_RESET  = 8'h00;
   // external clock: sixteen clock periods per bit
   localparam int EXT_DIV      = 16;
   localparam int HALF_BIT     = 8;
   localparam int DATA_BITS    = 8;
   localparam int FIFO_WIDTH   = 8;
   localparam int FIFO_DEPTH   = 16;
   localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
   typedef enum logic [2:0] {
      RX_IDLE  = 3'b001,
      RX_SHIFT = 3'b010,
      RX_STOP  = 3'b100
   } rx_state_t;
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_SHIFT = 3'b010,
      TX_STOP  = 3'b100
   } tx_state_t;
   // divisor lookup for the 4-bit rate field; zero means external 1/16
   function automatic logic [15:0] divisorOf(input logic [3:0] code);
      logic [15:0] d;
      d = 16'h0010;
      case (code)
         4'h1: d = 16'h9000;
         4'h2: d = 16'h6000;
         4'h3: d = 16'h4180;
         4'h4: d = 16'h3580;
         4'h5: d = 16'h3000;
         4'h6: d = 16'h1800;
         4'h7: d = 16'h0c00;
         4'h8: d = 16'h0600;
         4'h9: d = 16'h0400;
         4'ha: d = 16'h0300;
         4'hb: d = 16'h0200;
         4'hc: d = 16'h0180;
         4'hd: d = 16'h0100;
         4'he: d = 16'h00c0;
         4'hf: d = 16'h0060;
         default: d = 16'h0010;
      endcase
      return d;
   endfunction
endpackage
`default_nettype wire

/* logic/echo_fifo.sv */
`default_nettype none
module echo_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } fifo_state_t;
   fifo_state_t s_r;
   fifo_state_t s_nxt;
   logic        doWr;
   logic        doRd;

   always_comb begin
      s_nxt = s_r;
      doWr = inValid && (s_r.cnt != (AW+1)'(DEPTH));
      doRd = (s_r.cnt != '0) && outReady;
      if (doWr) begin
         s_nxt.mem[s_r.wp] = inData;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (doRd) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      if (doWr && !doRd) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (doRd && !doWr) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r <= '0;
      end else if (clkEn) begin
         s_r <= s_nxt;
      end
   end

   assign inReady  = (s_r.cnt != (AW+1)'(DEPTH));
   assign outValid = (s_r.cnt != '0);
   assign outData  = s_r.mem[s_r.rp];
endmodule
`default_nettype wire

/* logic/uart_baud_divider_loopback.sv */
// How it works
// - rate code zero: bit rate is clock/16
// - codes 1-7 pick divisors 36864..3072
// - codes 8-15 pick divisors 1536..96
// - external clocking: sixteen clocks per bit
// - no internal loop-back path exists
// - echo mode retransmits each character that reaches the holding register
// - control bit 4 shares transmit clock
// - command bit 4 selects echo mode
// - command bits 3:2 = 10 mute transmit irq
// - command bit 1 zero mutes receive irq
// - echo mode forces request-to-send low
// - echo overrun idles mark until read
//
// The register addresses and the APB register port were decided locally.
`default_nettype none
module uart_baud_divider_loopback
   import baud_echo_pkg::*;
(
   // clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial line and modem controls
   input  wire logic        rxData,
   output logic             txData,
   output logic             reqToSend,
   output logic             termReady,
   // divided 1/16 sub-bit tick (sixteen per bit), for observation
   output logic             bitTick
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  cmd;
      logic [15:0] divCnt;
      logic [15:0] divLoad;
      logic [3:0]  subCnt;
      logic        tick;
      rx_state_t   rxSt;
      logic [3:0]  rxPh;
      logic [2:0]  rxBit;
      logic [7:0]  rxSh;
      logic [7:0]  rxHold;
      logic        rxStart;
      logic        rxFull;
      logic        overrun;
      logic        muteTx;
      tx_state_t   txSt;
      logic [3:0]  txPh;
      logic [2:0]  txBit;
      logic [7:0]  txSh;
      logic        txLine;
      logic        rtsHigh;
      logic [31:0] rdata;
      logic        ready;
      logic        rxM;
      logic        rxS;
   } core_state_t;
   core_state_t s_r;
   core_state_t s_nxt;

   logic       fInValid;
   logic       fInReady;
   logic [7:0] fInData;
   logic       fOutValid;
   logic       fOutReady;
   logic [7:0] fOutData;
   logic       apbWrite;
   logic       apbRead;
   logic       echoOn;

   // received characters queue here before retransmission
   echo_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .clkEn    (clkEn),
      .inValid  (fInValid),
      .inReady  (fInReady),
      .inData   (fInData),
      .outValid (fOutValid),
      .outReady (fOutReady),
      .outData  (fOutData)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      apbWrite = psel && penable && pwrite && !s_r.ready;
      apbRead  = psel && penable && !pwrite && !s_r.ready;
      echoOn   = s_r.cmd[ECHO_BIT] && s_r.cmd[ENABLE_BIT];
      fInValid = 1'b0;
      fInData  = s_r.rxSh;
      fOutReady = 1'b0;

      // the raw line passes two flops before anything reads it
      s_nxt.rxM = rxData;
      s_nxt.rxS = s_r.rxM;

      // one-cycle ready keeps every access at exactly two bus cycles
      s_nxt.ready = psel && penable && !s_r.ready;

      // bit-rate generation: tick is the 1/16 sub-bit clock
      s_nxt.tick = 1'b0;
      if (s_r.divCnt <= 16'h0001) begin
         s_nxt.divCnt = s_r.divLoad;
         s_nxt.divLoad = divisorOf(s_r.ctrl[DIV_LSB +: 4]) / 16'(EXT_DIV);
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.divCnt = s_r.divCnt - 16'h0001;
      end

      // receiver, clocked by the transmit tick; rx clock select is the
      // only source here so holds by construction
      if (s_r.tick) begin
         s_nxt.rxPh = s_r.rxPh + 4'h1;
         case (s_r.rxSt)
            RX_IDLE: begin
               s_nxt.rxPh = 4'h0;
               if (!s_r.rxS && s_r.cmd[ENABLE_BIT]) begin
                  s_nxt.rxSt = RX_SHIFT;
                  s_nxt.rxPh = 4'(16 - HALF_BIT);
                  s_nxt.rxBit = 3'h0;
                  s_nxt.rxStart = 1'b1;
               end
            end
            RX_SHIFT: begin
               // first mid-bit sample is the start bit: checked, not stored
               if (s_r.rxPh == 4'hf && s_r.rxStart) begin
                  s_nxt.rxStart = 1'b0;
                  if (s_r.rxS) begin
                     s_nxt.rxSt = RX_IDLE;
                  end
               end else if (s_r.rxPh == 4'hf) begin
                  s_nxt.rxSh = {s_r.rxS, s_r.rxSh[7:1]};
                  s_nxt.rxBit = s_r.rxBit + 3'h1;
                  if (s_r.rxBit == 3'(DATA_BITS - 1)) begin
                     s_nxt.rxSt = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (s_r.rxPh == 4'hf) begin
                  s_nxt.rxSt = RX_IDLE;
                  if (s_r.rxFull) begin
                     s_nxt.overrun = 1'b1;
                     s_nxt.muteTx = echoOn;
                  end else begin
                     s_nxt.rxHold = s_r.rxSh;
                     s_nxt.rxFull = 1'b1;
                     fInValid = echoOn && !s_r.muteTx;
                  end
               end
            end
            default: s_nxt.rxSt = RX_IDLE;
         endcase
      end

      // transmitter: drains echoed characters at once
      if (s_r.tick) begin
         s_nxt.txPh = s_r.txPh + 4'h1;
         case (s_r.txSt)
            TX_IDLE: begin
               s_nxt.txLine = 1'b1;
               s_nxt.txPh = 4'h0;
               if (fOutValid) begin
                  fOutReady = 1'b1;
                  s_nxt.txSh = fOutData;
                  s_nxt.txLine = 1'b0;
                  s_nxt.txBit = 3'h0;
                  s_nxt.txSt = TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (s_r.txPh == 4'hf) begin
                  s_nxt.txLine = s_r.txSh[0];
                  s_nxt.txSh = {1'b1, s_r.txSh[7:1]};
                  s_nxt.txBit = s_r.txBit + 3'h1;
                  if (s_r.txBit == 3'(DATA_BITS - 1)) begin
                     s_nxt.txSt = TX_STOP;
                  end
               end
            end
            // two passes: end of the last data bit, then a full stop bit
            TX_STOP: begin
               if (s_r.txPh == 4'hf) begin
                  s_nxt.txLine = 1'b1;
                  s_nxt.txBit = s_r.txBit + 3'h1;
                  if (s_r.txBit != 3'h0) begin
                     s_nxt.txSt = TX_IDLE;
                  end
               end
            end
            default: s_nxt.txSt = TX_IDLE;
         endcase
      end

      // register access; a read of the data register releases the mute
      if (apbWrite) begin
         if (paddr == CTRL_OFF) begin
            s_nxt.ctrl = pwdata[7:0];
         end else if (paddr == CMD_OFF) begin
            s_nxt.cmd = pwdata[7:0];
         end
      end
      if (apbRead) begin
         if (paddr == CTRL_OFF) begin
            s_nxt.rdata = {24'h000000, s_r.ctrl};
         end else if (paddr == CMD_OFF) begin
            s_nxt.rdata = {24'h000000, s_r.cmd};
         end else if (paddr == STATUS_OFF) begin
            s_nxt.rdata = {28'h0000000, s_r.muteTx, echoOn, s_r.overrun, s_r.rxFull};
         end else if (paddr == RXDATA_OFF) begin
            s_nxt.rdata = {24'h000000, s_r.rxHold};
            s_nxt.rxFull = 1'b0;
            s_nxt.overrun = 1'b0;
            s_nxt.muteTx = 1'b0;
         end else begin
            s_nxt.rdata = UNMAPPED_VALUE;
         end
      end
      // request-to-send is active low; echo forces it low
      s_nxt.rtsHigh = !echoOn;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RESET;
         s_r.cmd <= CMD_RESET;
         s_r.divCnt <= 16'h0001;
         s_r.divLoad <= 16'h0001;
         s_r.rxSt <= RX_IDLE;
         s_r.txSt <= TX_IDLE;
         s_r.txLine <= 1'b1;
         s_r.rtsHigh <= 1'b1;
         s_r.rxM <= 1'b1;
         s_r.rxS <= 1'b1;
      end else if (clkEn) begin
         s_r <= s_nxt;
      end
   end

   // loop-back to the modem side is external gating; nothing here reroutes
   assign txData    = s_r.txLine;
   assign reqToSend = s_r.rtsHigh;
   assign termReady = !s_r.cmd[ENABLE_BIT];
   assign prdata    = s_r.rdata;
   assign pready    = s_r.ready;
   assign pslverr   = 1'b0;
   assign bitTick   = s_r.tick;

   ////////////////////////////////////////////////////////////////////////
   a_rts_echo_low: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && echoOn |=> !reqToSend) else $error("rts not low in echo");
   a_mute_idle_mark: assert property (@(posedge ref_clk) disable iff (rst)
      s_r.muteTx && s_r.txSt == TX_IDLE |-> txData) else $error("muted line not mark");
   a_apb_two_cycle: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && psel && penable && !pready |=> pready) else $error("pready late");
   a_pready_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      clkEn && pready |=> !pready) else $error("pready held");
   a_echo_push_gate: assert property (@(posedge ref_clk) disable iff (rst)
      fInValid |-> echoOn && !s_r.muteTx) else $error("echo push while off");
   a_stop_bit_mark: assert property (@(posedge ref_clk) disable iff (rst)
      s_r.txSt == TX_STOP && s_r.txBit == 3'h1 |-> txData) else $error("stop not mark");
endmodule
`default_nettype wire

/* verification/link_partner.sv */
`default_nettype none
module link_partner #(
   parameter int BIT_CYCLES = 16
) (
   // clock
   input  wire logic ref_clk,
   // serial lines, device side
   input  wire logic txData,
   output logic      rxData
);
   timeunit 1ns;
   timeprecision 1ps;
   // loop-back gating stays off, so each byte heard with a mark stop bit is queued
   localparam logic LOOPBACK_EN = 1'b0;
   logic [7:0] heard[$];
   initial rxData = 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   // 8N1, lsb first, line idles at mark
   task automatic sendByte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxData <= frame[i];
         repeat (BIT_CYCLES) @(posedge ref_clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // samples mid-bit; a start glitch shorter than half a bit is not rejected
   initial begin : listen
      logic [7:0] b;
      forever begin
         @(negedge txData);
         repeat (BIT_CYCLES / 2) @(posedge ref_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge ref_clk);
            b[i] = txData;
         end
         repeat (BIT_CYCLES) @(posedge ref_clk);
         if (!LOOPBACK_EN && txData === 1'b1) heard.push_back(b);
      end
   end
endmodule
`default_nettype wire

/* verification/uart_baud_divider_loopback_test.sv */
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module uart_baud_divider_loopback_test;
   import baud_echo_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, rst, clkEn, psel, penable, pwrite, rxData;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, txData, reqToSend, termReady, bitTick;
   int          n_fail, samples_checked, cnt;
   int          divs[16] = '{16, 36864, 24576, 16768, 13696, 12288, 6144, 3072,
                             1536, 1024, 768, 512, 384, 256, 192, 96};
   uart_baud_divider_loopback uart_baud_divider_loopback_i (
      .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxData(rxData), .txData(txData),
      .reqToSend(reqToSend), .termReady(termReady), .bitTick(bitTick));
   link_partner #(.BIT_CYCLES(16)) link_partner_i (
      .ref_clk(ref_clk), .txData(txData), .rxData(rxData));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic waitTick();
      cnt = 0;
      do begin @(posedge ref_clk); cnt++; end while (bitTick !== 1'b1);
   endtask
   task automatic summarize();
      $display("checked %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // longest tick period is 2304 cycles; the 60000-cycle limit lies well above the whole run
   initial begin
      #600_000;
      n_fail++;
      summarize();
   end
   initial begin
      rst = 1'b1; clkEn = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0000_0000; n_fail = 0; samples_checked = 0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      `CHK(txData, 1'b1)
      `CHK(reqToSend, 1'b1)
      apb(1'b0, CTRL_OFF, 32'h0); `CHK(rd, 32'h0)
      apb(1'b0, CMD_OFF, 32'h0); `CHK(rd, 32'h0)
      apb(1'b1, 8'h10, 32'hffff_ffff);
      apb(1'b0, 8'h10, 32'h0); `CHK(rd, 32'h0)
      $display("test reset done");
      // each code: skip the reload period, then time one full tick period
      for (int c = 1; c <= 16; c++) begin
         apb(1'b1, CTRL_OFF, {27'h0, 1'b1, 4'(c % 16)});
         waitTick(); waitTick(); waitTick();
         `CHK(cnt, divs[c % 16] / 16)
      end
      apb(1'b0, CTRL_OFF, 32'h0); `CHK(rd, 32'h10)
      cnt = 0;
      repeat (32) begin @(posedge ref_clk); if (bitTick === 1'b1) cnt++; end
      `CHK(cnt, 32)
      $display("test rates done");
      // receiver on, echo off: nothing comes back on the line
      apb(1'b1, CMD_OFF, 32'h01);
      link_partner_i.sendByte(8'h5a);
      repeat (480) @(posedge ref_clk);
      `CHK(link_partner_i.heard.size(), 0)
      `CHK(termReady, 1'b0)
      apb(1'b0, RXDATA_OFF, 32'h0); `CHK(rd, 32'h5a)
      $display("test no loop done");
      apb(1'b1, CMD_OFF, 32'h19);
      apb(1'b0, CMD_OFF, 32'h0); `CHK(rd, 32'h19)
      `CHK(reqToSend, 1'b0)
      link_partner_i.sendByte(8'ha5);
      apb(1'b0, RXDATA_OFF, 32'h0); `CHK(rd, 32'ha5)
      link_partner_i.sendByte(8'h3c);
      repeat (640) @(posedge ref_clk);
      `CHK(link_partner_i.heard.size(), 2)
      if (link_partner_i.heard.size() == 2) begin
         `CHK(link_partner_i.heard[0], 8'ha5)
         `CHK(link_partner_i.heard[1], 8'h3c)
      end
      apb(1'b0, RXDATA_OFF, 32'h0); `CHK(rd, 32'h3c)
      // second character overruns the unread first: echo goes quiet
      link_partner_i.sendByte(8'h11);
      link_partner_i.sendByte(8'h22);
      repeat (640) @(posedge ref_clk);
      `CHK(link_partner_i.heard.size(), 3)
      apb(1'b0, STATUS_OFF, 32'h0); `CHK(rd, 32'hf)
      apb(1'b0, RXDATA_OFF, 32'h0); `CHK(rd, 32'h11)
      apb(1'b0, STATUS_OFF, 32'h0); `CHK(rd, 32'h4)
      apb(1'b1, CMD_OFF, 32'h00);
      @(posedge ref_clk);
      `CHK(reqToSend, 1'b1)
      `CHK(termReady, 1'b1)
      $display("test echo done");
      summarize();
   end
endmodule
`default_nettype wire
